/* src/exr_pkg.sv */
/*
 * Package for the excitation and reference configuration register bank:
 * register offsets, field positions, reset values and select codes.
 * Assumes a 32-bit AHB-Lite slave with one register per aligned word.
 */
package exr_pkg;

    // ------------------------------------------------------------------
    // Register indices (printed offsets; byte address is four times)
    // ------------------------------------------------------------------
    localparam logic [7:0] ROUTE_IDX = 8'h0d;
    localparam logic [7:0] MAG_IDX   = 8'h0e;
    localparam logic [7:0] REF_IDX   = 8'h0f;
    localparam logic [7:0] TSRC_IDX  = 8'h10;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] ROUTE_RST = 8'hbb;
    localparam logic [7:0] MAG_RST   = 8'h00;
    localparam logic [7:0] REF_RST   = 8'h00;
    localparam logic [7:0] TSRC_RST  = 8'h00;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int SECOND_LSB   = 4;
    localparam int FIRST_LSB    = 0;
    localparam int REF_POS_LSB  = 3;
    localparam int REF_NEG_LSB  = 0;
    localparam int TEST_CON_BIT = 7;
    localparam int TEST_LVL_LSB = 0;

    // ------------------------------------------------------------------
    // Codes
    // ------------------------------------------------------------------
    localparam logic [3:0] PIN_LAST   = 4'h9;
    localparam logic [3:0] PIN_COMMON = 4'ha;
    localparam logic [3:0] PIN_NONE   = 4'hb;
    localparam logic [3:0] LVL_OFF    = 4'h0;
    localparam logic [3:0] LVL_MAX    = 4'ha;
    localparam logic [2:0] REF_INT    = 3'h0;
    localparam logic [2:0] REF_SUPPLY = 3'h4;
    localparam logic [4:0] TEST_LVL_MAX_UP = 5'h09;
    localparam logic [4:0] TEST_LVL_MIN_DN = 5'h11;
    localparam logic [4:0] TEST_LVL_MAX_DN = 5'h19;

    // ------------------------------------------------------------------
    // Bus constants
    // ------------------------------------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;

endpackage : exr_pkg

/* src/exr_src_decode.sv */
/*
 * Decodes one current source's routing and level codes into the
 * effective drive codes; reserved codes fall back to safe values.
 * Assumes codes come from registers on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module exr_src_decode (
    input  wire logic [3:0] route_code,
    input  wire logic [3:0] level_code,
    output logic      [3:0] route_eff,
    output logic      [3:0] level_eff,
    output logic            active
);

    // Reserved routes act as no connection, reserved levels as off
    always_comb begin
        route_eff = (route_code > exr_pkg::PIN_NONE) ?
                    exr_pkg::PIN_NONE : route_code;
        level_eff = (level_code > exr_pkg::LVL_MAX) ?
                    exr_pkg::LVL_OFF : level_code;
        active    = (route_eff != exr_pkg::PIN_NONE) &&
                    (level_eff != exr_pkg::LVL_OFF);
    end

endmodule : exr_src_decode

`default_nettype wire

/* src/exr_ref_decode.sv */
/*
 * Decodes the reference selects and the test-source level code;
 * reserved codes fall back to the internal reference or to off.
 * Assumes codes come from registers on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module exr_ref_decode (
    input  wire logic [2:0] pos_code,
    input  wire logic [2:0] neg_code,
    input  wire logic [4:0] test_code,
    input  wire logic       test_connect,
    output logic      [2:0] pos_eff,
    output logic      [2:0] neg_eff,
    output logic            test_connect_eff
);

    logic test_legal;

    always_comb begin
        pos_eff = (pos_code > exr_pkg::REF_SUPPLY) ?
                  exr_pkg::REF_INT : pos_code;
        neg_eff = (neg_code > exr_pkg::REF_SUPPLY) ?
                  exr_pkg::REF_INT : neg_code;
        test_legal = (test_code <= exr_pkg::TEST_LVL_MAX_UP) ||
                     ((test_code >= exr_pkg::TEST_LVL_MIN_DN) &&
                      (test_code <= exr_pkg::TEST_LVL_MAX_DN));
        test_connect_eff = test_connect && test_legal;
    end

endmodule : exr_ref_decode

`default_nettype wire

/* src/exr_regs.sv */
/*
 * Excitation and reference configuration register bank: AHB-Lite slave
 * holding current-source routing and level, reference selects and the
 * positive test-source control, with decoded static outputs.
 * Assumes a single AHB-Lite master, 32-bit words, sys_clk at 100 MHz.
 */
// Operation
// - Upper routing nibble routes second source
// - Lower routing nibble routes first source
// - Upper level nibble sets second source current
// - Lower level nibble sets first source current
// - Positive reference select, bits 7:6 read zero
// - Negative reference select in bits 2:0
// - Test-source control at 10h, bits 6:5 zero
// - Level and reference registers reset to 00h
// - Routing register at 0Dh resets to BBh
`timescale 1ns/1ps
`default_nettype none

module exr_regs (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        clk_en,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [3:0]  first_source_pin_select,
    output logic      [3:0]  second_source_pin_select,
    output logic      [3:0]  first_source_level,
    output logic      [3:0]  second_source_level,
    output logic             first_source_active,
    output logic             second_source_active,
    output logic      [2:0]  reference_positive_select,
    output logic      [2:0]  reference_negative_select,
    output logic             positive_test_output_connect,
    output logic      [4:0]  positive_test_level
);

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic logic [1:0] reg_sel(input logic [31:0] a);
        logic [29:0] idx;
        idx = a[31:2];
        if (idx == {22'h000000, exr_pkg::ROUTE_IDX})
            reg_sel = 2'h0;
        else if (idx == {22'h000000, exr_pkg::MAG_IDX})
            reg_sel = 2'h1;
        else if (idx == {22'h000000, exr_pkg::REF_IDX})
            reg_sel = 2'h2;
        else
            reg_sel = 2'h3;
    endfunction : reg_sel

    function automatic logic is_mapped(input logic [31:0] a);
        logic [29:0] idx;
        idx = a[31:2];
        is_mapped = (idx >= {22'h000000, exr_pkg::ROUTE_IDX}) &&
                    (idx <= {22'h000000, exr_pkg::TSRC_IDX});
    endfunction : is_mapped

    // ------------------------------------------------------------------
    // Address phase capture
    // ------------------------------------------------------------------
    logic       wr_pend_q;
    logic [1:0] wr_sel_q;
    logic       addr_ok;
    logic [1:0] addr_sel;
    logic       take;

    assign take = clk_en && hsel && hready &&
                  ((htrans == exr_pkg::HTRANS_NONSEQ) ||
                   (htrans == exr_pkg::HTRANS_SEQ));
    assign addr_ok  = is_mapped(haddr);
    assign addr_sel = reg_sel(haddr);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wr_pend_q <= 1'b0;
            wr_sel_q  <= 2'h0;
        end else if (clk_en) begin
            wr_pend_q <= take && hwrite && addr_ok;
            if (take)
                wr_sel_q <= addr_sel;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] route_q;
    logic [7:0] mag_q;
    logic [5:0] ref_q;
    logic       tcon_q;
    logic [4:0] tlvl_q;
    logic [7:0] wbyte;

    assign wbyte = hwdata[7:0];

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            route_q <= exr_pkg::ROUTE_RST;
        end else if (clk_en && wr_pend_q && wr_sel_q == 2'h0) begin
            route_q <= wbyte;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mag_q <= exr_pkg::MAG_RST;
        end else if (clk_en && wr_pend_q && wr_sel_q == 2'h1) begin
            mag_q <= wbyte;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ref_q <= exr_pkg::REF_RST[5:0];
        end else if (clk_en && wr_pend_q && wr_sel_q == 2'h2) begin
            ref_q <= wbyte[5:0];
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tcon_q <= exr_pkg::TSRC_RST[exr_pkg::TEST_CON_BIT];
            tlvl_q <= exr_pkg::TSRC_RST[4:0];
        end else if (clk_en && wr_pend_q && wr_sel_q == 2'h3) begin
            tcon_q <= wbyte[exr_pkg::TEST_CON_BIT];
            tlvl_q <= wbyte[4:0];
        end
    end

    // ------------------------------------------------------------------
    // Read data and response
    // ------------------------------------------------------------------
    logic [7:0] rd_byte;
    logic       fwd;

    // Read in the data phase of a write to the same word sees the new byte
    assign fwd = wr_pend_q && (wr_sel_q == addr_sel);

    always_comb begin
        unique case (addr_sel)
            2'h0: rd_byte = fwd ? wbyte : route_q;
            2'h1: rd_byte = fwd ? wbyte : mag_q;
            2'h2: rd_byte = {2'b00, fwd ? wbyte[5:0] : ref_q};
            2'h3: rd_byte = fwd ? {wbyte[7], 2'b00, wbyte[4:0]}
                                : {tcon_q, 2'b00, tlvl_q};
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            hrdata <= 32'h00000000;
        end else if (clk_en && take) begin
            hrdata <= (!hwrite && addr_ok) ? {24'h000000, rd_byte}
                                           : 32'h00000000;
        end
    end

    // Zero wait states, always OKAY
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else if (clk_en) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Decode of effective drive codes
    // ------------------------------------------------------------------
    logic [3:0] r1_eff;
    logic [3:0] r2_eff;
    logic [3:0] l1_eff;
    logic [3:0] l2_eff;
    logic       a1;
    logic       a2;
    logic [2:0] pos_eff;
    logic [2:0] neg_eff;
    logic       tcon_eff;

    exr_src_decode u_first (
        .route_code (route_q[3:0]),
        .level_code (mag_q[3:0]),
        .route_eff  (r1_eff),
        .level_eff  (l1_eff),
        .active     (a1)
    );

    exr_src_decode u_second (
        .route_code (route_q[7:4]),
        .level_code (mag_q[7:4]),
        .route_eff  (r2_eff),
        .level_eff  (l2_eff),
        .active     (a2)
    );

    exr_ref_decode u_ref (
        .pos_code         (ref_q[5:3]),
        .neg_code         (ref_q[2:0]),
        .test_code        (tlvl_q),
        .test_connect     (tcon_q),
        .pos_eff          (pos_eff),
        .neg_eff          (neg_eff),
        .test_connect_eff (tcon_eff)
    );

    // ------------------------------------------------------------------
    // Registered outputs (one cycle after the stored value)
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            first_source_pin_select      <= exr_pkg::PIN_NONE;
            second_source_pin_select     <= exr_pkg::PIN_NONE;
            first_source_level           <= exr_pkg::LVL_OFF;
            second_source_level          <= exr_pkg::LVL_OFF;
            first_source_active          <= 1'b0;
            second_source_active         <= 1'b0;
            reference_positive_select    <= exr_pkg::REF_INT;
            reference_negative_select    <= exr_pkg::REF_INT;
            positive_test_output_connect <= 1'b0;
            positive_test_level          <= 5'h00;
        end else if (clk_en) begin
            first_source_pin_select      <= r1_eff;
            second_source_pin_select     <= r2_eff;
            first_source_level           <= l1_eff;
            second_source_level          <= l2_eff;
            first_source_active          <= a1;
            second_source_active         <= a2;
            reference_positive_select    <= pos_eff;
            reference_negative_select    <= neg_eff;
            positive_test_output_connect <= tcon_eff;
            positive_test_level          <= tlvl_q;
        end
    end

endmodule : exr_regs

`default_nettype wire

/* testbench/exr_tb_fn.svh */
/* Expected-value helpers: safe decodes and byte addresses.
   Assumes inclusion inside a module body. */
function automatic logic [3:0] rt_safe(input logic [3:0] c);
    return (c > exr_pkg::PIN_NONE) ? exr_pkg::PIN_NONE : c;
endfunction : rt_safe
function automatic logic [3:0] lv_safe(input logic [3:0] c);
    return (c > exr_pkg::LVL_MAX) ? exr_pkg::LVL_OFF : c;
endfunction : lv_safe
function automatic logic [2:0] rf_safe(input logic [2:0] c);
    return (c > exr_pkg::REF_SUPPLY) ? exr_pkg::REF_INT : c;
endfunction : rf_safe
function automatic logic tl_ok(input logic [4:0] c);
    return c <= 5'h09 || (c >= 5'h11 && c <= 5'h19);
endfunction : tl_ok
function automatic logic act(input logic [3:0] r, input logic [3:0] l);
    return rt_safe(r) != 4'hb && lv_safe(l) != 4'h0;
endfunction : act
function automatic logic [31:0] ad(input logic [7:0] i);
    return {22'h0, i, 2'b00};
endfunction : ad

/* testbench/exr_regs_chk.sv */
/* Port checker for exr_regs: decodes, reserved bits, freeze, reset.
   Assumes one clock domain; bound to every exr_regs instance. */
`timescale 1ns/1ps
`default_nettype none
module exr_regs_chk (
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic        clk_en,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [3:0]  first_source_pin_select,
    input wire logic [3:0]  first_source_level,
    input wire logic        first_source_active,
    input wire logic [2:0]  reference_positive_select,
    input wire logic [2:0]  reference_negative_select,
    input wire logic        positive_test_output_connect,
    input wire logic [4:0]  positive_test_level
);
    `include "exr_tb_fn.svh"
    logic        dp_q;
    logic        dp_wr_q;
    logic [31:0] dp_a_q;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            dp_q    <= 1'b0;
            dp_wr_q <= 1'b0;
            dp_a_q  <= 32'h0;
        end else if (clk_en) begin
            dp_q    <= hsel && hready && htrans[1];
            dp_wr_q <= hwrite;
            dp_a_q  <= haddr;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    sequence dp_at(logic [7:0] i);
        dp_q && dp_a_q == ad(i);
    endsequence
    sequence lands(logic [7:0] i);
        dp_at(i) ##0 dp_wr_q ##0 clk_en [*3];
    endsequence
    okay_resp_a: assert property (hresp == 1'b0)
        else $error("response not okay");
    ready_high_a: assert property (hreadyout == 1'b1)
        else $error("slave not ready");
    route_wr_a: assert property (lands(exr_pkg::ROUTE_IDX) |->
        first_source_pin_select == rt_safe($past(hwdata[3:0], 2)))
        else $error("route output wrong");
    level_wr_a: assert property (lands(exr_pkg::MAG_IDX) |->
        first_source_level == lv_safe($past(hwdata[3:0], 2)))
        else $error("level output wrong");
    ref_wr_a: assert property (lands(exr_pkg::REF_IDX) |->
        reference_positive_select == rf_safe($past(hwdata[5:3], 2)) &&
        reference_negative_select == rf_safe($past(hwdata[2:0], 2)))
        else $error("reference output wrong");
    test_wr_a: assert property (lands(exr_pkg::TSRC_IDX) |->
        positive_test_level == $past(hwdata[4:0], 2) &&
        positive_test_output_connect ==
        ($past(hwdata[7], 2) && tl_ok($past(hwdata[4:0], 2))))
        else $error("test source output wrong");
    active_rel_a: assert property (first_source_active ==
        act(first_source_pin_select, first_source_level))
        else $error("active flag wrong");
    rsvd_ref_a: assert property (dp_at(exr_pkg::REF_IDX) ##0 !dp_wr_q
        |-> hrdata[7:6] == 2'b00)
        else $error("reference reserved bits set");
    rsvd_test_a: assert property (dp_at(exr_pkg::TSRC_IDX) ##0 !dp_wr_q
        |-> hrdata[6:5] == 2'b00)
        else $error("test reserved bits set");
    freeze_a: assert property (!clk_en |=> $stable(hrdata) &&
        $stable({first_source_pin_select, positive_test_level}))
        else $error("state moved while frozen");
    rst_val_a: assert property ($rose(rstn) |->
        {first_source_pin_select, first_source_level} == 8'hb0 &&
        reference_positive_select == 3'h0 && hrdata == 32'h0)
        else $error("reset values wrong");
endmodule : exr_regs_chk
bind exr_regs exr_regs_chk u_chk (.sys_clk, .rstn, .clk_en, .hsel, .haddr,
    .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
    .first_source_pin_select, .first_source_level, .first_source_active,
    .reference_positive_select, .reference_negative_select,
    .positive_test_output_connect, .positive_test_level);
`default_nettype wire

/* testbench/testbench.sv */
/* Self-checking bench for exr_regs over AHB-Lite.
   Assumes the checker is bound and the helper header is reachable. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    `include "exr_tb_fn.svh"
    logic        sys_clk, rstn, clk_en, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd, ex;
    logic [1:0]  htrans;
    logic [2:0]  hsize, rp, rn, j;
    logic [3:0]  p1, p2, l1, l2, k;
    logic [4:0]  tlvl, t;
    logic        a1, a2, tcon;
    int          n_mismatch = 0, check_count = 0, cyc = 0;
    exr_regs dut (.sys_clk, .rstn, .clk_en, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .first_source_pin_select(p1), .second_source_pin_select(p2),
        .first_source_level(l1), .second_source_level(l2),
        .first_source_active(a1), .second_source_active(a2),
        .reference_positive_select(rp), .reference_negative_select(rn),
        .positive_test_output_connect(tcon), .positive_test_level(tlvl));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [31:0] a, d);
        hsel   <= 1'b1;
        htrans <= exr_pkg::HTRANS_NONSEQ;
        haddr  <= a;
        hwrite <= w;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdc
    task automatic rst_chk();
        rdc(ad(exr_pkg::ROUTE_IDX), 32'hbb);
        rdc(ad(exr_pkg::MAG_IDX), 32'h0);
        rdc(ad(exr_pkg::REF_IDX), 32'h0);
        rdc(ad(exr_pkg::TSRC_IDX), 32'h0);
        chk({16'h0, p2, p1, l2, l1}, 32'hbb00);
        chk({18'h0, a2, a1, tcon, tlvl, rp, rn}, 32'h0);
    endtask : rst_chk
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    initial begin
        rstn   = 1'b0;
        clk_en = 1'b1;
        hsel   = 1'b0;
        haddr  = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0;
        repeat (8) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        rst_chk();
        for (int c = 0; c < 16; c++) begin
            k = c[3:0];
            bus(1'b1, ad(exr_pkg::ROUTE_IDX), {24'h0, k, ~k});
            bus(1'b1, ad(exr_pkg::MAG_IDX), {24'h0, ~k, k});
            rdc(ad(exr_pkg::ROUTE_IDX), {24'h0, k, ~k});
            ex = {16'h0, rt_safe(k), rt_safe(~k), lv_safe(~k), lv_safe(k)};
            chk({16'h0, p2, p1, l2, l1}, ex);
            chk({30'h0, a2, a1}, {30'h0, act(k, ~k), act(~k, k)});
        end
        for (int c = 0; c < 8; c++) begin
            j = c[2:0];
            bus(1'b1, ad(exr_pkg::REF_IDX), {24'h0, 2'b00, j, ~j});
            rdc(ad(exr_pkg::REF_IDX), {24'h0, 2'b00, j, ~j});
            chk({26'h0, rp, rn}, {26'h0, rf_safe(j), rf_safe(~j)});
        end
        for (int c = 0; c < 64; c++) begin
            t = c[4:0];
            bus(1'b1, ad(exr_pkg::TSRC_IDX), {24'h0, c[5], 2'b11, t});
            rdc(ad(exr_pkg::TSRC_IDX), {24'h0, c[5], 2'b00, t});
            chk({26'h0, tcon, tlvl}, {26'h0, c[5] && tl_ok(t), t});
        end
        bus(1'b1, ad(8'h11), 32'hffff_ffff);
        rdc(ad(8'h11), 32'h0);
        rdc(ad(8'h0c), 32'h0);
        bus(1'b1, ad(exr_pkg::ROUTE_IDX), 32'hffff_ff5a);
        rdc(ad(exr_pkg::ROUTE_IDX), 32'h5a);
        clk_en <= 1'b0;
        bus(1'b1, ad(exr_pkg::ROUTE_IDX), 32'h11);
        clk_en <= 1'b1;
        rdc(ad(exr_pkg::ROUTE_IDX), 32'h5a);
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        rst_chk();
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
